/* rtl/ipb_bank.sv */
/*
 holds the apb slave and the four priority registers of the bank, and drives every
 field out to the interrupt arbitration logic.
 assumes an apb3/apb4 master on pclk; pstrb may be tied high by an apb3 master.
*/
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
module ipb_bank
    import ipb_pkg::*;
(
    input wire logic pclk, // clock, 50 MHz
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [31:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [3:0] pstrb, // apb byte strobes
    output logic [31:0] prdata, // apb read data, registered
    output logic pready, // apb ready, registered
    output logic pslverr, // apb error, registered
    output ipb_prios_t prios_q // priorities to the arbiter
);
    logic [15:0] regs [IPB_NUM_REGS];
    logic [IPB_NUM_REGS-1:0] wr_sel;
    logic [1:0] reg_idx;
    logic addr_hit;
    logic setup;
    logic access_end;

    function automatic logic [1:0] decode_idx(input logic [31:0] addr);
        logic [1:0] idx;
        idx = 2'h0;
        if (addr[IPB_AW-1:0] == IPB_OFS_CAPTURE) begin
            idx = 2'h0;
        end else if (addr[IPB_AW-1:0] == IPB_OFS_COMPARE) begin
            idx = 2'h1;
        end else if (addr[IPB_AW-1:0] == IPB_OFS_MOTOR_CAN_EXT) begin
            idx = 2'h2;
        end else begin
            idx = 2'h3;
        end
        return idx;
    endfunction

    function automatic ipb_prio_t field(input logic [15:0] r, input int lsb);
        return r[lsb +: IPB_FIELD_W];
    endfunction

    always_comb begin
        addr_hit = (paddr[31:IPB_AW] == '0) && (paddr[1:0] == 2'h0);
        reg_idx = decode_idx(paddr);
        // answer lands one cycle after setup: ready goes high in the access phase
        setup = psel && !penable;
        // writes land only at the edge that completes the access phase
        access_end = psel && penable && pready;
        for (int i = 0; i < IPB_NUM_REGS; i++) begin
            wr_sel[i] = access_end && pwrite && addr_hit && (reg_idx == i[1:0]);
        end
    end

    for (genvar g = 0; g < IPB_NUM_REGS; g++) begin : g_reg
        ipb_reg16 u_reg (
            .pclk(pclk),
            .presetn(presetn),
            .wr_en(wr_sel[g]),
            .be(pstrb[1:0]),
            .wdata(pwdata[15:0]),
            .value_q(regs[g])
        );
    end

    // apb handshake: one wait-free access phase, error on unmapped address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= setup && !addr_hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite && addr_hit) begin
            prdata <= {16'h0000, regs[reg_idx] & IPB_IMPL_MASK};
        end else if (setup) begin
            prdata <= 32'h0000_0000;
        end
    end

    // field map onto the arbiter's priority inputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prios_q <= '0;
        end else begin
            prios_q.capture6_priority <= field(regs[0], IPB_FIELD3_LSB);
            prios_q.capture5_priority <= field(regs[0], IPB_FIELD2_LSB);
            prios_q.capture4_priority <= field(regs[0], IPB_FIELD1_LSB);
            prios_q.capture3_priority <= field(regs[0], IPB_FIELD0_LSB);
            prios_q.compare8_priority <= field(regs[1], IPB_FIELD3_LSB);
            prios_q.compare7_priority <= field(regs[1], IPB_FIELD2_LSB);
            prios_q.compare6_priority <= field(regs[1], IPB_FIELD1_LSB);
            prios_q.compare5_priority <= field(regs[1], IPB_FIELD0_LSB);
            prios_q.motor_pulse_priority <= field(regs[2], IPB_FIELD3_LSB);
            prios_q.second_can_priority <= field(regs[2], IPB_FIELD2_LSB);
            prios_q.external4_priority <= field(regs[2], IPB_FIELD1_LSB);
            prios_q.external3_priority <= field(regs[2], IPB_FIELD0_LSB);
            prios_q.fault_a_priority <= field(regs[3], IPB_FIELD3_LSB);
            prios_q.low_voltage_priority <= field(regs[3], IPB_FIELD2_LSB);
            prios_q.converter_iface_priority <= field(regs[3], IPB_FIELD1_LSB);
            prios_q.encoder_priority <= field(regs[3], IPB_FIELD0_LSB);
        end
    end

    property p_ready_one;
        @(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready ##1 !pready;
    endproperty
    a_ready_one: assert property (p_ready_one)
        else $error("ready not one cycle");

    property p_ready_pulse;
        @(posedge pclk) disable iff (!presetn)
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("ready held too long");

    property p_err_with_ready;
        @(posedge pclk) disable iff (!presetn)
        pslverr |-> pready;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready)
        else $error("error without ready");

    property p_unmapped_err;
        @(posedge pclk) disable iff (!presetn)
        psel && !penable && paddr[31:IPB_AW] != '0 |=> pslverr && pready;
    endproperty
    a_unmapped_err: assert property (p_unmapped_err)
        else $error("unmapped access not refused");

    property p_miss_rd_zero;
        @(posedge pclk) disable iff (!presetn)
        psel && !penable && !addr_hit |=> prdata == 32'h0000_0000 && pslverr;
    endproperty
    a_miss_rd_zero: assert property (p_miss_rd_zero)
        else $error("refused access returned data");

    property p_rd_hi_zero;
        @(posedge pclk) disable iff (!presetn)
        pready |-> prdata[31:16] == 16'h0000
            && (prdata[15:0] & ~IPB_IMPL_MASK) == 16'h0000;
    endproperty
    a_rd_hi_zero: assert property (p_rd_hi_zero)
        else $error("unimplemented bits read nonzero");

    property p_rd_data;
        @(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && addr_hit
        |=> prdata[15:0] == ($past(regs[reg_idx]) & IPB_IMPL_MASK);
    endproperty
    a_rd_data: assert property (p_rd_data)
        else $error("read data differs from register");

    property p_prdata_hold;
        @(posedge pclk) disable iff (!presetn)
        !(psel && !penable) |=> $stable(prdata);
    endproperty
    a_prdata_hold: assert property (p_prdata_hold)
        else $error("read data changed outside setup");

    property p_miss_no_write;
        @(posedge pclk) disable iff (!presetn)
        psel && penable && pready && !addr_hit
        |=> $stable(regs[0]) && $stable(regs[1])
            && $stable(regs[2]) && $stable(regs[3]);
    endproperty
    a_miss_no_write: assert property (p_miss_no_write)
        else $error("refused write changed a register");

    property p_rd_no_write;
        @(posedge pclk) disable iff (!presetn)
        !(psel && penable && pready && pwrite)
        |=> $stable(regs[0]) && $stable(regs[1])
            && $stable(regs[2]) && $stable(regs[3]);
    endproperty
    a_rd_no_write: assert property (p_rd_no_write)
        else $error("register changed without a write");

    property p_lane_hi_kept;
        @(posedge pclk) disable iff (!presetn)
        wr_sel[0] && !pstrb[1] |=> regs[0][15:8] == $past(regs[0][15:8]);
    endproperty
    a_lane_hi_kept: assert property (p_lane_hi_kept)
        else $error("unstrobed upper byte written");

    property p_reset_zero;
        @(posedge pclk)
        $rose(presetn) |-> prios_q == '0 && prdata == 32'h0000_0000
            && !pready && !pslverr;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("outputs not clear after reset");

    property p_cap6_map;
        @(posedge pclk) disable iff (!presetn)
        ##1 prios_q.capture6_priority == $past(regs[0][14:12]);
    endproperty
    a_cap6_map: assert property (p_cap6_map)
        else $error("capture6 map wrong");

    property p_cap5_map;
        @(posedge pclk) disable iff (!presetn)
        ##1 prios_q.capture5_priority == $past(regs[0][10:8]);
    endproperty
    a_cap5_map: assert property (p_cap5_map)
        else $error("capture5 map wrong");

    property p_cap4_map;
        @(posedge pclk) disable iff (!presetn)
        ##1 prios_q.capture4_priority == $past(regs[0][6:4]);
    endproperty
    a_cap4_map: assert property (p_cap4_map)
        else $error("capture4 map wrong");

    property p_cap3_map;
        @(posedge pclk) disable iff (!presetn)
        ##1 prios_q.capture3_priority == $past(regs[0][2:0]);
    endproperty
    a_cap3_map: assert property (p_cap3_map)
        else $error("capture3 map wrong");

    property p_cmp8_map;
        @(posedge pclk) disable iff (!presetn)
        ##1 prios_q.compare8_priority == $past(regs[1][14:12]);
    endproperty
    a_cmp8_map: assert property (p_cmp8_map)
        else $error("compare8 map wrong");

    property p_cmp7_map;
        @(posedge pclk) disable iff (!presetn)
        ##1 prios_q.compare7_priority == $past(regs[1][10:8]);
    endproperty
    a_cmp7_map: assert property (p_cmp7_map)
        else $error("compare7 map wrong");

    property p_cmp6_map;
        @(posedge pclk) disable iff (!presetn)
        ##1 prios_q.compare6_priority == $past(regs[1][6:4]);
    endproperty
    a_cmp6_map: assert property (p_cmp6_map)
        else $error("compare6 map wrong");

    property p_cmp5_map;
        @(posedge pclk) disable iff (!presetn)
        ##1 prios_q.compare5_priority == $past(regs[1][2:0]);
    endproperty
    a_cmp5_map: assert property (p_cmp5_map)
        else $error("compare5 map wrong");

    property p_motor_map;
        @(posedge pclk) disable iff (!presetn)
        ##1 prios_q.motor_pulse_priority == $past(regs[2][14:12]);
    endproperty
    a_motor_map: assert property (p_motor_map)
        else $error("motor map wrong");

    property p_can_map;
        @(posedge pclk) disable iff (!presetn)
        ##1 prios_q.second_can_priority == $past(regs[2][10:8]);
    endproperty
    a_can_map: assert property (p_can_map)
        else $error("second can map wrong");

    property p_ext4_map;
        @(posedge pclk) disable iff (!presetn)
        ##1 prios_q.external4_priority == $past(regs[2][6:4]);
    endproperty
    a_ext4_map: assert property (p_ext4_map)
        else $error("external4 map wrong");

    property p_ext3_map;
        @(posedge pclk) disable iff (!presetn)
        ##1 prios_q.external3_priority == $past(regs[2][2:0]);
    endproperty
    a_ext3_map: assert property (p_ext3_map)
        else $error("external3 map wrong");

    property p_fault_map;
        @(posedge pclk) disable iff (!presetn)
        ##1 prios_q.fault_a_priority == $past(regs[3][14:12]);
    endproperty
    a_fault_map: assert property (p_fault_map)
        else $error("fault a map wrong");

    property p_lvd_map;
        @(posedge pclk) disable iff (!presetn)
        ##1 prios_q.low_voltage_priority == $past(regs[3][10:8]);
    endproperty
    a_lvd_map: assert property (p_lvd_map)
        else $error("low voltage map wrong");

    property p_conv_map;
        @(posedge pclk) disable iff (!presetn)
        ##1 prios_q.converter_iface_priority == $past(regs[3][6:4]);
    endproperty
    a_conv_map: assert property (p_conv_map)
        else $error("converter map wrong");

    property p_enc_map;
        @(posedge pclk) disable iff (!presetn)
        ##1 prios_q.encoder_priority == $past(regs[3][2:0]);
    endproperty
    a_enc_map: assert property (p_enc_map)
        else $error("encoder map wrong");

    property p_follow;
        @(posedge pclk) disable iff (!presetn)
        wr_sel[0] && pstrb[1]
        |=> ##1 prios_q.capture6_priority == $past(pwdata[14:12], 2);
    endproperty
    a_follow: assert property (p_follow)
        else $error("priority output lags write");

    property p_follow_cmp;
        @(posedge pclk) disable iff (!presetn)
        wr_sel[1] && pstrb[1]
        |=> ##1 prios_q.compare7_priority == $past(pwdata[10:8], 2);
    endproperty
    a_follow_cmp: assert property (p_follow_cmp)
        else $error("compare7 output lags write");

    property p_follow_can;
        @(posedge pclk) disable iff (!presetn)
        wr_sel[2] && pstrb[1]
        |=> ##1 prios_q.second_can_priority == $past(pwdata[10:8], 2);
    endproperty
    a_follow_can: assert property (p_follow_can)
        else $error("second can output lags write");

    property p_follow_enc;
        @(posedge pclk) disable iff (!presetn)
        wr_sel[3] && pstrb[0]
        |=> ##1 prios_q.encoder_priority == $past(pwdata[2:0], 2);
    endproperty
    a_follow_enc: assert property (p_follow_enc)
        else $error("encoder output lags write");
endmodule

/* rtl/ipb_pkg.sv */
/*
 holds the offsets, field layouts, reset values and the priority carrier type of the
 interrupt priority bank for sources seven to ten.
 assumes a 32-bit apb with word-aligned registers.
*/
package ipb_pkg;
    localparam int IPB_NUM_REGS = 4;
    localparam int IPB_AW = 4;
    localparam logic [IPB_AW-1:0] IPB_OFS_CAPTURE = 4'h0;
    localparam logic [IPB_AW-1:0] IPB_OFS_COMPARE = 4'h4;
    localparam logic [IPB_AW-1:0] IPB_OFS_MOTOR_CAN_EXT = 4'h8;
    localparam logic [IPB_AW-1:0] IPB_OFS_FAULT_MISC = 4'hc;
    localparam int IPB_FIELD_W = 3;
    localparam int IPB_FIELD3_LSB = 12;
    localparam int IPB_FIELD2_LSB = 8;
    localparam int IPB_FIELD1_LSB = 4;
    localparam int IPB_FIELD0_LSB = 0;
    localparam logic [15:0] IPB_IMPL_MASK = 16'h7777;
    localparam logic [15:0] IPB_REG_RESET = 16'h0000;
    localparam logic [2:0] IPB_PRIO_LOWEST = 3'h0;
    localparam logic [2:0] IPB_PRIO_HIGHEST = 3'h7;

    typedef logic [2:0] ipb_prio_t;

    typedef struct packed {
        ipb_prio_t capture6_priority;
        ipb_prio_t capture5_priority;
        ipb_prio_t capture4_priority;
        ipb_prio_t capture3_priority;
        ipb_prio_t compare8_priority;
        ipb_prio_t compare7_priority;
        ipb_prio_t compare6_priority;
        ipb_prio_t compare5_priority;
        ipb_prio_t motor_pulse_priority;
        ipb_prio_t second_can_priority;
        ipb_prio_t external4_priority;
        ipb_prio_t external3_priority;
        ipb_prio_t fault_a_priority;
        ipb_prio_t low_voltage_priority;
        ipb_prio_t converter_iface_priority;
        ipb_prio_t encoder_priority;
    } ipb_prios_t;
endpackage

/* rtl/ipb_reg16.sv */
/*
 holds one 16-bit priority register with four 3-bit fields.
 assumes a decoded write strobe and byte enables on pclk.
*/
`timescale 1ns/100ps
module ipb_reg16
    import ipb_pkg::*;
(
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, active low
    input wire logic wr_en, // write strobe
    input wire logic [1:0] be, // byte enables
    input wire logic [15:0] wdata, // write data
    output logic [15:0] value_q // stored value
);
    logic [15:0] lane_mask;

    always_comb begin
        lane_mask = {{8{be[1]}}, {8{be[0]}}} & IPB_IMPL_MASK;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value_q <= IPB_REG_RESET;
        end else if (wr_en) begin
            value_q <= (value_q & ~lane_mask) | (wdata & lane_mask);
        end
    end

    property p_unimpl_zero;
        @(posedge pclk) disable iff (!presetn)
        (value_q & ~IPB_IMPL_MASK) == 16'h0000;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero)
        else $error("unimplemented bit set");

    property p_write_lands;
        @(posedge pclk) disable iff (!presetn)
        wr_en && (be == 2'h3) |=> value_q == ($past(wdata) & IPB_IMPL_MASK);
    endproperty
    a_write_lands: assert property (p_write_lands)
        else $error("write not stored");

    property p_hold;
        @(posedge pclk) disable iff (!presetn)
        !wr_en |=> $stable(value_q);
    endproperty
    a_hold: assert property (p_hold)
        else $error("register changed without write");
endmodule

/* bench/ipb_testbench.sv */
/*
 self-checking bench for the priority bank: apb reads and writes, field mapping,
 byte strobes, refused addresses and a reset in mid-run.
 assumes ipb_bank raises pready in the cycle after setup.
*/
`timescale 1ns/100ps
module testbench
    import ipb_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    ipb_prios_t prios_q;
    logic [31:0] rd;
    logic er;
    logic [31:0] ofs [4];
    int fail_count = 0;
    int n_tests = 0;

    always #10 pclk = ~pclk;

    ipb_bank dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .prios_q(prios_q));

    task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask

    // one transfer; the wait is bounded, a missing pready is a mismatch
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
        input logic [3:0] s);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        er = pslverr;
        chk("pready", 48'h1, {47'h0, pready});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [11:0] pk(input logic [15:0] v);
        return {v[14:12], v[10:8], v[6:4], v[2:0]};
    endfunction

    task automatic t_reset();
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, ofs[i], 32'h0, 4'hf);
            chk("reset value", 48'h0, {16'h0, rd});
        end
        chk("reset priorities", 48'h0, prios_q);
    endtask

    task automatic t_rw();
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, ofs[i], 32'hffffffff, 4'hf);
            apb(1'b0, ofs[i], 32'h0, 4'hf);
            chk("all ones readback", 48'h7777, {16'h0, rd});
            chk("slave error", 48'h0, {47'h0, er});
        end
    endtask

    task automatic t_fields();
        logic [15:0] v [4];
        v = '{16'h7654, 16'h3210, 16'hf5a3, 16'h1e6d};
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, ofs[i], {16'hffff, v[i]}, 4'hf);
            apb(1'b0, ofs[i], 32'h0, 4'hf);
            chk("pattern readback", {32'h0, v[i] & 16'h7777}, {16'h0, rd});
        end
        repeat (2) @(posedge pclk);
        chk("priorities", {pk(v[0]), pk(v[1]), pk(v[2]), pk(v[3])},
            prios_q);
        chk("capture6 level", 48'h7, {45'h0, prios_q.capture6_priority});
        chk("compare5 level", 48'h0, {45'h0, prios_q.compare5_priority});
        chk("external3 level", 48'h3, {45'h0, prios_q.external3_priority});
    endtask

    task automatic t_strobe();
        apb(1'b1, ofs[0], 32'h0, 4'h1);
        apb(1'b0, ofs[0], 32'h0, 4'hf);
        chk("low byte only", 48'h7600, {16'h0, rd});
    endtask

    task automatic t_bad();
        apb(1'b0, 32'h10, 32'h0, 4'hf);
        chk("unmapped error", 48'h1, {47'h0, er});
        chk("unmapped data", 48'h0, {16'h0, rd});
        apb(1'b1, 32'h2, 32'hffff, 4'hf);
        chk("misaligned error", 48'h1, {47'h0, er});
        apb(1'b0, ofs[0], 32'h0, 4'hf);
        chk("refused write kept out", 48'h7600, {16'h0, rd});
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        ofs[0] = {28'h0, IPB_OFS_CAPTURE};
        ofs[1] = {28'h0, IPB_OFS_COMPARE};
        ofs[2] = {28'h0, IPB_OFS_MOTOR_CAN_EXT};
        ofs[3] = {28'h0, IPB_OFS_FAULT_MISC};
        t_reset();
        t_rw();
        t_fields();
        t_strobe();
        t_bad();
        t_reset();
        end_of_test();
    end

    // run needs about a hundred cycles; 5000 is ample
    initial begin
        #100000;
        fail_count++;
        end_of_test();
    end
endmodule
